// *** inc/asbc_pkg.sv ***
// shared constants and types for the converter sequence and buffer control block
package asbc_pkg;

   localparam logic [3:0]  AddrCtrlTwo    = 4'h0;
   localparam logic [3:0]  AddrIrqStatus  = 4'h1;
   localparam logic [3:0]  AddrIrqEnable  = 4'h2;
   localparam logic [3:0]  AddrIrqClear   = 4'h3;

   localparam int          RefSelLsb      = 13;
   localparam int          OffCalBit      = 12;
   localparam int          ScanEnBit      = 10;
   localparam int          FillStatBit    = 7;
   localparam int          SeqPerIrqLsb   = 2;
   localparam int          SplitBufBit    = 1;
   localparam int          AltSampleBit   = 0;

   localparam logic [31:0] CtrlWriteMask  = 32'h0000_f43f;
   localparam logic [31:0] CtrlResetValue = 32'h0000_0000;
   localparam logic [3:0]  ResultHalfLen  = 4'h8;

   localparam logic [2:0]  RefSupplyGnd   = 3'h0;
   localparam logic [2:0]  RefExtPosGnd   = 3'h1;
   localparam logic [2:0]  RefSupplyExtNeg = 3'h2;
   localparam logic [2:0]  RefExtBoth     = 3'h3;

   localparam int          IrqBits        = 2;
   localparam int          IrqSeqDoneBit  = 0;
   localparam int          IrqHalfSwapBit = 1;

   typedef struct packed {
      logic [2:0] referenceSelect;
      logic       offsetCalibration;
      logic       inputScanEnable;
      logic [3:0] sequencesPerInterrupt;
      logic       splitBufferMode;
      logic       alternateSampleMode;
   } asbc_cfg_t;

   typedef struct packed {
      logic highRefExternal;
      logic lowRefExternal;
   } asbc_ref_t;

   typedef struct packed {
      logic       shaToLowRef;
      logic       scanInputs;
      logic       useSetB;
   } asbc_route_t;

endpackage : asbc_pkg

// *** rtl/asbc_seq_count.sv ***
// counts finished sequences and flags the interrupt point
`timescale 1ns/10ps
`default_nettype none
module asbc_seq_count
(
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       seqDone,
   input  wire logic       restart,
   input  wire logic [3:0] limit,
   output logic            groupDone
);

   logic [3:0] count_q;

   assign groupDone = seqDone && (count_q == limit); // [R5]

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         count_q <= 4'h0;
      else if (restart || groupDone)
         count_q <= 4'h0;
      else if (seqDone)
         count_q <= count_q + 4'h1;
   end

endmodule : asbc_seq_count
`default_nettype wire

// *** rtl/asbc_result_addr.sv ***
// result buffer write pointer, contiguous or split halves
`timescale 1ns/10ps
`default_nettype none
module asbc_result_addr
(
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       splitMode,
   input  wire logic       fillHigh,
   input  wire logic       resultValid,
   input  wire logic       groupDone,
   input  wire logic       restart,
   output logic [3:0]      writeIndex
);

   logic [2:0] low_q;
   logic       top_q;

   // in split mode the top address bit follows the half being filled
   assign writeIndex = splitMode ? {fillHigh, low_q} : {top_q, low_q}; // [R6]

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         low_q <= 3'h0;
         top_q <= 1'b0;
      end
      else if (restart || groupDone)
      begin
         low_q <= 3'h0;
         top_q <= 1'b0;
      end
      else if (resultValid)
      begin
         low_q <= low_q + 3'h1;
         // wraps inside one half when split, across all 16 words otherwise
         if (!splitMode && (low_q == 3'h7))
            top_q <= ~top_q; // [R6]
      end
   end

endmodule : asbc_result_addr
`default_nettype wire

// *** rtl/asbc_top.sv ***
// second converter control register with sequencing, routing and interrupt logic
// Function
// R1 - reference field picks high and low references
// R2 - offset calibration ties both inputs low
// R3 - scan bit enables input scanning
// R4 - read-only fill status shows active half
// R5 - interrupt every N plus one sequences
// R6 - split mode uses two eight-word halves
// R7 - alternate mode uses A then B alternating
// R8 - unimplemented bits read back as zero
// R9 - reset clears fields; status write ignored
// R10 - status toggles when a half completes
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module asbc_top
(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic [31:0]      regRdata,
   input  wire logic        sampleStart,
   input  wire logic        resultValid,
   input  wire logic        seqDone,
   input  wire logic        convEnable,
   output asbc_pkg::asbc_ref_t   refSel,
   output asbc_pkg::asbc_route_t route,
   output logic [3:0]      resultIndex,
   output logic            seqIrqPulse,
   output logic            irq
);

   ////////////////////////////////////////////////////////////////////////////
   // control register

   logic [31:0]                  ctrl_q;
   logic                         fillHigh_q;
   logic                         setB_q;
   logic                         convEnable_q;
   logic [asbc_pkg::IrqBits-1:0] irqStat_q;
   logic [asbc_pkg::IrqBits-1:0] irqEn_q;
   logic [31:0]                  rdata_q;
   logic                         groupDone;
   logic                         restart;
   logic [asbc_pkg::IrqBits-1:0] irqEvent;
   asbc_pkg::asbc_cfg_t          cfg;

   // only implemented writable bits are kept; status bit is never written
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_q <= asbc_pkg::CtrlResetValue; // [R9]
      else if (regWrite && (regAddr == asbc_pkg::AddrCtrlTwo))
         ctrl_q <= regWdata & asbc_pkg::CtrlWriteMask; // [R8] [R9]
   end

   assign cfg.referenceSelect       = ctrl_q[asbc_pkg::RefSelLsb +: 3];
   assign cfg.offsetCalibration     = ctrl_q[asbc_pkg::OffCalBit];
   assign cfg.inputScanEnable       = ctrl_q[asbc_pkg::ScanEnBit];
   assign cfg.sequencesPerInterrupt = ctrl_q[asbc_pkg::SeqPerIrqLsb +: 4];
   assign cfg.splitBufferMode       = ctrl_q[asbc_pkg::SplitBufBit];
   assign cfg.alternateSampleMode   = ctrl_q[asbc_pkg::AltSampleBit];

   ////////////////////////////////////////////////////////////////////////////
   // reference and input routing

   always_comb
   begin
      refSel = '0;
      unique case (cfg.referenceSelect)
         asbc_pkg::RefExtPosGnd:    refSel.highRefExternal = 1'b1; // [R1]
         asbc_pkg::RefSupplyExtNeg: refSel.lowRefExternal  = 1'b1; // [R1]
         asbc_pkg::RefExtBoth:
         begin
            refSel.highRefExternal = 1'b1; // [R1]
            refSel.lowRefExternal  = 1'b1;
         end
         default:                   refSel = '0; // supply and ground [R1]
      endcase
   end

   // calibration overrides scan routing only; set A/B selection is not gated by it
   assign route.shaToLowRef = cfg.offsetCalibration; // [R2]
   assign route.scanInputs  = cfg.inputScanEnable && !cfg.offsetCalibration; // [R3]
   assign route.useSetB     = cfg.alternateSampleMode && setB_q; // [R7]

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   // converter enable is same-domain logic; a rising edge restarts counting
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         convEnable_q <= 1'b0;
      else
         convEnable_q <= convEnable;
   end

   assign restart = convEnable && !convEnable_q;

   asbc_seq_count u_count
   (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .seqDone   (seqDone),
      .restart   (restart),
      .limit     (cfg.sequencesPerInterrupt),
      .groupDone (groupDone)
   );

   assign seqIrqPulse = groupDone; // [R5]

   // first sample uses set A, then alternates each sample
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         setB_q <= 1'b0;
      else if (restart || !cfg.alternateSampleMode)
         setB_q <= 1'b0; // [R7]
      else if (sampleStart)
         setB_q <= ~setB_q; // [R7]
   end

   // half swap only in split mode; held at zero otherwise
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         fillHigh_q <= 1'b0; // [R9]
      else if (!cfg.splitBufferMode || restart)
         fillHigh_q <= 1'b0; // [R4]
      else if (groupDone)
         fillHigh_q <= ~fillHigh_q; // [R10]
   end

   asbc_result_addr u_addr
   (
      .core_clk    (core_clk),
      .arst_n      (arst_n),
      .splitMode   (cfg.splitBufferMode),
      .fillHigh    (fillHigh_q),
      .resultValid (resultValid),
      .groupDone   (groupDone),
      .restart     (restart),
      .writeIndex  (resultIndex)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, enable and clear

   assign irqEvent[asbc_pkg::IrqSeqDoneBit]  = groupDone;
   assign irqEvent[asbc_pkg::IrqHalfSwapBit] = groupDone && cfg.splitBufferMode;

   genvar gi;
   generate
      for (gi = 0; gi < asbc_pkg::IrqBits; gi++)
      begin : g_irq
         // a set in the clear cycle wins so no event is lost
         always_ff @(posedge core_clk or negedge arst_n)
         begin
            if (!arst_n)
               irqStat_q[gi] <= 1'b0;
            else if (irqEvent[gi])
               irqStat_q[gi] <= 1'b1;
            else if (regWrite && (regAddr == asbc_pkg::AddrIrqClear) && regWdata[gi])
               irqStat_q[gi] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         irqEn_q <= '0;
      else if (regWrite && (regAddr == asbc_pkg::AddrIrqEnable))
         irqEn_q <= regWdata[asbc_pkg::IrqBits-1:0];
   end

   assign irq = |(irqStat_q & irqEn_q);

   ////////////////////////////////////////////////////////////////////////////
   // read port: data in the cycle after the strobe only

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_q <= 32'h0000_0000;
      else if (regRead)
      begin
         unique case (regAddr)
            asbc_pkg::AddrCtrlTwo:
            begin
               rdata_q <= ctrl_q; // [R8]
               rdata_q[asbc_pkg::FillStatBit] <= fillHigh_q; // [R4]
            end
            asbc_pkg::AddrIrqStatus: rdata_q <= {30'h0, irqStat_q};
            asbc_pkg::AddrIrqEnable: rdata_q <= {30'h0, irqEn_q};
            default:                 rdata_q <= 32'h0000_0000;
         endcase
      end
      else
         rdata_q <= 32'h0000_0000;
   end

   assign regRdata = rdata_q;

endmodule : asbc_top
`default_nettype wire

// *** dv/asbc_asserts.sv ***
// concurrent checks on the sequence and buffer control block
`timescale 1ns/10ps
`default_nettype none
module asbc_asserts
(
   input wire logic                  core_clk,
   input wire logic                  arst_n,
   input wire logic [3:0]            regAddr,
   input wire logic [31:0]           regWdata,
   input wire logic                  regWrite,
   input wire logic                  regRead,
   input wire logic [31:0]           regRdata,
   input wire logic                  sampleStart,
   input wire logic                  seqDone,
   input wire logic                  convEnable,
   input wire asbc_pkg::asbc_ref_t   refSel,
   input wire asbc_pkg::asbc_route_t route,
   input wire logic                  seqIrqPulse
);
   logic [15:0] cfg_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the control word, so outputs are judged without looking inside
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         cfg_q <= 16'h0000;
      else if (regWrite && regAddr == asbc_pkg::AddrCtrlTwo)
         cfg_q <= regWdata[15:0];
   sequence s_ctrl_rd;
      regRead && regAddr == asbc_pkg::AddrCtrlTwo;
   endsequence
   sequence s_alt_smp;
      cfg_q[0] && sampleStart && convEnable && !regWrite;
   endsequence
   a_ref_map : assert property (
      refSel.highRefExternal == (cfg_q[15:13] == 3'h1 || cfg_q[15:13] == 3'h3) &&
      refSel.lowRefExternal == (cfg_q[15:13] == 3'h2 || cfg_q[15:13] == 3'h3))
      else $error("reference selection wrong");
   a_offset_calibration_route : assert property (route.shaToLowRef == cfg_q[12])
      else $error("calibration routing wrong");
   a_scan_gate : assert property (route.scanInputs == (cfg_q[10] && !cfg_q[12]))
      else $error("scan enable wrong");
   a_ctrl_zeros : assert property (s_ctrl_rd |=> (regRdata & 32'hffff_0b40) == 32'h0)
      else $error("unimplemented bits not zero");
   a_fill_unsplit : assert property (s_ctrl_rd ##0 !cfg_q[1] |=> !regRdata[7])
      else $error("fill status set outside split mode");
   a_rdata_idle : assert property (!regRead |=> regRdata == 32'h0)
      else $error("read data outside its cycle");
   a_pulse_cause : assert property (seqIrqPulse |-> seqDone)
      else $error("interrupt pulse without sequence end");
   a_zero_every : assert property (cfg_q[5:2] == 4'h0 && seqDone |-> seqIrqPulse)
      else $error("missed interrupt with count zero");
   a_alt_off : assert property (!cfg_q[0] |-> !route.useSetB)
      else $error("set B used with alternation off");
   a_alt_toggle : assert property (s_alt_smp |=> route.useSetB != $past(route.useSetB))
      else $error("set did not alternate");
endmodule : asbc_asserts
`default_nettype wire

// *** dv/asbc_conv_model.sv ***
// converter core stand-in: sample, result and sequence-end pulses
`timescale 1ns/10ps
`default_nettype none
module asbc_conv_model
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic convEnable,
   input wire logic slow,
   output logic     sampleStart,
   output logic     resultValid,
   output logic     seqDone
);
   logic       run_q;
   logic [2:0] phase_q;
   logic [2:0] last;
   ////////////////////////////////////////////////////////////////////////////////
   // start one cycle late so the restart edge never meets a sample
   assign last = slow ? 3'h6 : 3'h2;
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         run_q <= 1'b0;
      else
         run_q <= convEnable;
   always_ff @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         phase_q <= 3'h0;
      else if (!run_q)
         phase_q <= 3'h0;
      else
         phase_q <= (phase_q == last) ? 3'h0 : phase_q + 3'h1;
   assign sampleStart = run_q && phase_q == 3'h0;
   assign resultValid = run_q && phase_q == last;
   assign seqDone     = resultValid;
endmodule : asbc_conv_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the sequence and buffer control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic core_clk, arst_n, regWrite, regRead, sampleStart, resultValid, seqDone;
   logic convEnable, slow, seqIrqPulse, irq, split, mon, fill, ab, swaps, hits;
   logic [3:0] regAddr, resultIndex, n, k, tot;
   logic [31:0] regWdata, regRdata, d, v;
   asbc_pkg::asbc_ref_t refSel;
   asbc_pkg::asbc_route_t route;
   integer seed, n_fail, comparisons, i, seqs;
   integer cyc = 0;
   asbc_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .sampleStart(sampleStart), .resultValid(resultValid), .seqDone(seqDone),
      .convEnable(convEnable), .refSel(refSel), .route(route), .resultIndex(resultIndex),
      .seqIrqPulse(seqIrqPulse), .irq(irq));
   asbc_conv_model u_conv (.core_clk(core_clk), .arst_n(arst_n), .convEnable(convEnable),
      .slow(slow), .sampleStart(sampleStart), .resultValid(resultValid), .seqDone(seqDone));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] refExp(input logic [2:0] f);
      return {f == 3'h1 || f == 3'h3, f == 3'h2 || f == 3'h3};
   endfunction : refExp
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] w);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= w;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] r);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 r = regRdata;
   endtask : rd
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end
   // expected pointer, interrupt point and set selection per event
   always @(posedge core_clk)
      if (mon)
      begin
         if (sampleStart)
         begin
            chk(route.useSetB, ab);
            ab = ~ab;
         end
         if (resultValid)
            chk(resultIndex, split ? {fill, k[2:0]} : tot);
         if (seqDone)
         begin
            chk(seqIrqPulse, k == n);
            // pointer restarts from word zero after every interrupt point
            tot = (k == n) ? 4'h0 : tot + 4'h1;
            seqs = seqs + 1;
            hits = hits | (k == n);
            swaps = swaps | (split && k == n);
            fill = fill ^ (split && k == n);
            k = (k == n) ? 4'h0 : k + 4'h1;
         end
      end
   initial
   begin
      seed = 32'h3999;
      n_fail = 0;
      comparisons = 0;
      mon = 1'b0;
      arst_n = 1'b0;
      {regAddr, regWdata, regWrite, regRead, convEnable, slow} = '0;
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      rd(asbc_pkg::AddrCtrlTwo, d);
      chk(d, asbc_pkg::CtrlResetValue);
      rd(asbc_pkg::AddrIrqStatus, d);
      chk(d, 32'h0);
      for (i = 0; i < 9; i++)
      begin
         v = $random(seed);
         v[15:13] = i[2:0];
         if (i == 8)
            v = 32'hffff_ffff;
         wr(asbc_pkg::AddrCtrlTwo, v);
         chk(refSel, refExp(v[15:13]));
         chk(route.shaToLowRef, v[12]);
         chk(route.scanInputs, v[10] & ~v[12]);
         rd(asbc_pkg::AddrCtrlTwo, d);
         chk(d, v & asbc_pkg::CtrlWriteMask);
      end
      rd(4'h9, d);
      chk(d, 32'h0);
      for (i = 0; i < 6; i++)
      begin
         n = (i % 3 == 2) ? 4'hf : 4'(i % 3);
         split = (i >= 3);
         wr(asbc_pkg::AddrCtrlTwo, {26'h0, n, split, 1'b1});
         wr(asbc_pkg::AddrIrqClear, 32'h3);
         wr(asbc_pkg::AddrIrqEnable, 32'h3);
         d = $random(seed);
         slow <= d[0];
         {k, tot, fill, ab, hits, swaps} = '0;
         seqs = 0;
         @(posedge core_clk);
         convEnable <= 1'b1;
         mon = 1'b1;
         while (seqs < 25)
            @(posedge core_clk);
         convEnable <= 1'b0;
         repeat (3) @(posedge core_clk);
         mon = 1'b0;
         rd(asbc_pkg::AddrCtrlTwo, d);
         chk(d[7], fill);
         rd(asbc_pkg::AddrIrqStatus, d);
         chk(d[1:0], {swaps, hits});
         chk(irq, 1'b1);
         wr(asbc_pkg::AddrIrqEnable, 32'h0);
         @(posedge core_clk);
         #1 chk(irq, 1'b0);
         wr(asbc_pkg::AddrIrqEnable, 32'h3);
         wr(asbc_pkg::AddrIrqClear, 32'h3);
         @(posedge core_clk);
         #1 chk(irq, 1'b0);
      end
      give_verdict();
   end
endmodule : testbench
bind asbc_top asbc_asserts u_chk (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
   .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .sampleStart(sampleStart), .seqDone(seqDone), .convEnable(convEnable),
   .refSel(refSel), .route(route), .seqIrqPulse(seqIrqPulse));
`default_nettype wire
